// ### src/ecc_pkg.sv
// package: constants and types of the ejector cycle counters and display
// ==========================================================================
// ==========================================================================
package ecc_pkg;

	// ==================================================================
	// timing
	localparam int unsigned CLK_HZ    = 50_000_000;
	localparam int unsigned HOLD_S    = 3;
	localparam int unsigned HOLD_CYC  = HOLD_S * CLK_HZ;
	localparam int unsigned BLINK_MS  = 250;
	localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
	localparam int          TW        = 28;
	localparam int          BW        = 24;

	// ==================================================================
	// counters
	localparam int          CW        = 30;
	localparam int          NPAIR     = 3;
	localparam logic [29:0] CNT_MAX   = 30'h3B9AC9FF;
	localparam int          PR_SUCT   = 0;
	localparam int          PR_VALVE  = 1;
	localparam int          PR_MON    = 2;

	// ==================================================================
	// menu items: 0..2 totals, 3..5 erasable, then the rest
	localparam logic [3:0]  IT_FIRST  = 4'h0;
	localparam logic [3:0]  IT_NCNT   = 4'h6;
	localparam logic [3:0]  IT_RESET  = 4'h6;
	localparam logic [3:0]  IT_PART   = 4'h7;
	localparam logic [3:0]  IT_SERIAL = 4'h8;
	localparam logic [3:0]  IT_LAST   = 4'h8;

	// ==================================================================
	// display blocks and points, dp[2] is the leftmost point
	localparam logic [1:0]  BLK_UNITS = 2'h0;
	localparam logic [1:0]  BLK_MILL  = 2'h2;
	localparam logic [1:0]  BLK_PNEND = 2'h3;
	localparam logic [2:0]  DP_UNITS  = 3'h1;
	localparam logic [2:0]  DP_MILL   = 3'h4;
	localparam logic [2:0]  DP_NONE   = 3'h0;
	localparam logic [3:0][2:0] PN_DP = {3'h0, 3'h4, 3'h4, 3'h1};
	localparam logic [3:0]  DIG_BLANK = 4'hF;

	// ==================================================================
	// synchronised pin inputs
	localparam int          NIN       = 5;
	localparam int          IN_SUCT   = 0;
	localparam int          IN_UP     = 1;
	localparam int          IN_DOWN   = 2;
	localparam int          IN_OK     = 3;
	localparam int          IN_MENU   = 4;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_BROWSE = 3'b001,
		ST_PIN    = 3'b010,
		ST_VIEW   = 3'b011,
		ST_FLASH  = 3'b100
	} ecc_state_t;

	typedef struct packed {
		logic [2:0][3:0] dig;
		logic [2:0]      dp;
		logic            blank;
	} ecc_disp_t;

	typedef struct packed {
		logic up;
		logic down;
		logic ok;
		logic menu;
	} ecc_btn_t;

	typedef logic [NPAIR-1:0][CW-1:0] ecc_cnt3_t;
	typedef logic [10:0][3:0]         ecc_pn_t;

endpackage

// ### src/ecc_counters_display.sv
// module: event counters and paged three-digit readout of the ejector
`timescale 1ns/1ps
`default_nettype none

module ecc_counters_display #(
	parameter int unsigned HOLD_CYCLES  = ecc_pkg::HOLD_CYC,
	parameter int unsigned BLINK_CYCLES = ecc_pkg::BLINK_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              suction_pin,
	input  wire logic              btn_up_pin,
	input  wire logic              btn_down_pin,
	input  wire logic              btn_ok_pin,
	input  wire logic              btn_menu_pin,
	input  wire logic              valve_switch,
	input  wire logic              condition_monitoring,
	input  wire logic              diag_out,
	input  wire logic              bus_clear,
	input  wire logic              pin_locked,
	input  wire logic              pin_ok,
	input  wire logic [26:0]       serial_num,
	input  wire ecc_pkg::ecc_pn_t  part_num,
	output var  ecc_pkg::ecc_disp_t display_q,
	output logic [3:0]             menu_item_q,
	output var  ecc_pkg::ecc_cnt3_t total_cnt_q,
	output var  ecc_pkg::ecc_cnt3_t erase_cnt_q
);
	import ecc_pkg::*;

	// ==================================================================
	// decimal conversion
	function automatic logic [35:0] ecc_bin2bcd(input logic [29:0] bin);
		logic [35:0] bcd;
		bcd = '0;
		for (int i = CW - 1; i >= 0; i--) begin
			for (int k = 0; k < 9; k++) begin
				if (bcd[k*4 +: 4] > 4'h4) begin
					bcd[k*4 +: 4] = bcd[k*4 +: 4] + 4'h3;
				end
			end
			bcd = {bcd[34:0], bin[i]};
		end
		return bcd;
	endfunction

	// ==================================================================
	// pin synchronisers and filtered levels
	logic [NIN-1:0][2:0] sync_q, sync_d;
	logic [NIN-1:0]      lvl_q, lvl_d, prev_q, prev_d;
	logic [NIN-1:0]      pins;
	logic                diag_q, diag_d;
	ecc_btn_t            held, prs;

	assign pins = {btn_menu_pin, btn_ok_pin, btn_down_pin, btn_up_pin,
		suction_pin};

	// a level counts only once the second and third stage agree
	for (genvar i = 0; i < NIN; i++) begin : g_sync
		always_comb begin
			sync_d[i] = {sync_q[i][1:0], pins[i]};
			lvl_d[i]  = (sync_q[i][1] == sync_q[i][2]) ? sync_q[i][2]
				: lvl_q[i];
			prev_d[i] = lvl_q[i];
		end
	end
	assign diag_d = diag_out;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_q <= '0;
			lvl_q  <= '0;
			prev_q <= '0;
			diag_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			lvl_q  <= lvl_d;
			prev_q <= prev_d;
			diag_q <= diag_d;
		end
	end

	assign held = '{up: lvl_q[IN_UP], down: lvl_q[IN_DOWN],
		ok: lvl_q[IN_OK], menu: lvl_q[IN_MENU]};
	assign prs = '{up: lvl_q[IN_UP] & ~prev_q[IN_UP],
		down: lvl_q[IN_DOWN] & ~prev_q[IN_DOWN],
		ok: lvl_q[IN_OK] & ~prev_q[IN_OK],
		menu: lvl_q[IN_MENU] & ~prev_q[IN_MENU]};

	// ==================================================================
	// counter pairs
	logic [NPAIR-1:0] ev;
	logic             panel_clr, clr_all;
	ecc_cnt3_t        total_cnt_d, erase_cnt_d;

	assign ev[PR_SUCT]  = lvl_q[IN_SUCT] & ~prev_q[IN_SUCT];
	assign ev[PR_VALVE] = valve_switch;
	assign ev[PR_MON]   = condition_monitoring | (diag_out & ~diag_q);
	assign clr_all      = panel_clr | bus_clear;

	// counts stop at nine digits rather than wrap to a small value
	always_comb begin
		for (int p = 0; p < NPAIR; p++) begin
			total_cnt_d[p] = total_cnt_q[p];
			erase_cnt_d[p] = erase_cnt_q[p];
			if (ev[p] && total_cnt_q[p] != CNT_MAX) begin
				total_cnt_d[p] = total_cnt_q[p] + 30'h1;
			end
			// an event in the clear cycle survives as a count of one
			if (clr_all) begin
				erase_cnt_d[p] = {29'h0, ev[p]};
			end else if (ev[p] && erase_cnt_q[p] != CNT_MAX) begin
				erase_cnt_d[p] = erase_cnt_q[p] + 30'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			total_cnt_q <= '0;
			erase_cnt_q <= '0;
		end else begin
			total_cnt_q <= total_cnt_d;
			erase_cnt_q <= erase_cnt_d;
		end
	end

	// ==================================================================
	// menu state machine
	ecc_state_t  st_q, st_d;
	logic [3:0]  sel_d;
	logic [1:0]  blk_q, blk_d;
	logic [TW-1:0] tmr_q, tmr_d, hold_last;

	assign hold_last = HOLD_CYCLES[TW-1:0] - 28'h1;

	always_comb begin
		st_d      = st_q;
		sel_d     = menu_item_q;
		blk_d     = blk_q;
		tmr_d     = '0;
		panel_clr = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (held.up && held.down) begin
					tmr_d = tmr_q + 28'h1;
					if (tmr_q == hold_last) begin
						st_d  = ST_BROWSE;
						sel_d = IT_FIRST;
						tmr_d = '0;
					end
				end
			end
			ST_BROWSE: begin
				if (prs.menu) begin
					st_d = ST_IDLE;
				end else if (menu_item_q == IT_RESET && held.ok) begin
					tmr_d = tmr_q + 28'h1;
					if (tmr_q == hold_last) begin
						st_d  = ST_FLASH;
						tmr_d = '0;
					end
				end else if (prs.ok) begin
					st_d  = pin_locked ? ST_PIN : ST_VIEW;
					blk_d = (menu_item_q == IT_SERIAL) ? BLK_MILL
						: BLK_UNITS;
				end else if (prs.up) begin
					sel_d = (menu_item_q == IT_LAST) ? IT_FIRST
						: menu_item_q + 4'h1;
				end else if (prs.down) begin
					sel_d = (menu_item_q == IT_FIRST) ? IT_LAST
						: menu_item_q - 4'h1;
				end
			end
			ST_PIN: begin
				if (prs.menu) begin
					st_d = ST_BROWSE;
				end else if (pin_ok) begin
					st_d = ST_VIEW;
				end
			end
			ST_VIEW: begin
				if (prs.menu) begin
					st_d = ST_BROWSE;
				end else if (menu_item_q == IT_PART) begin
					if (prs.down && blk_q != BLK_PNEND) begin
						blk_d = blk_q + 2'h1;
					end else if (prs.up && blk_q != BLK_UNITS) begin
						blk_d = blk_q - 2'h1;
					end
				end else if (prs.up && blk_q != BLK_MILL) begin
					blk_d = blk_q + 2'h1;
				end else if (prs.down && blk_q != BLK_UNITS) begin
					blk_d = blk_q - 2'h1;
				end
			end
			ST_FLASH: begin
				tmr_d = tmr_q + 28'h1;
				if (tmr_q == hold_last) begin
					panel_clr = 1'b1;
					st_d      = ST_BROWSE;
					tmr_d     = '0;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q        <= ST_IDLE;
			menu_item_q <= IT_FIRST;
			blk_q       <= BLK_UNITS;
			tmr_q       <= '0;
		end else begin
			st_q        <= st_d;
			menu_item_q <= sel_d;
			blk_q       <= blk_d;
			tmr_q       <= tmr_d;
		end
	end

	// ==================================================================
	// flash blinker and display drive
	logic [BW-1:0] blink_q, blink_d;
	logic          blank_q, blank_d;
	logic [29:0]   val;
	logic [35:0]   bcd;
	ecc_disp_t     display_d;

	always_comb begin
		blink_d = '0;
		blank_d = 1'b0;
		if (st_q == ST_FLASH) begin
			blink_d = blink_q + 24'h1;
			blank_d = blank_q;
			if (blink_q == BLINK_CYCLES[BW-1:0] - 24'h1) begin
				blink_d = '0;
				blank_d = ~blank_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			blink_q <= '0;
			blank_q <= 1'b0;
		end else begin
			blink_q <= blink_d;
			blank_q <= blank_d;
		end
	end

	// one shared converter; the selected value is converted again every cycle
	always_comb begin
		val = '0;
		if (menu_item_q == IT_SERIAL) begin
			val = {3'h0, serial_num};
		end else if (menu_item_q < IT_NCNT) begin
			val = (menu_item_q >= 4'h3) ? erase_cnt_q[menu_item_q - 4'h3]
				: total_cnt_q[menu_item_q[1:0]];
		end
		bcd = ecc_bin2bcd(val);
		display_d.dig   = {DIG_BLANK, DIG_BLANK, DIG_BLANK};
		display_d.dp    = DP_NONE;
		display_d.blank = 1'b0;
		case (st_q)
			ST_VIEW: begin
				if (menu_item_q == IT_PART) begin
					display_d.dp = PN_DP[blk_q];
					case (blk_q)
						2'h0: display_d.dig = {DIG_BLANK, part_num[10],
							part_num[9]};
						2'h1: display_d.dig = part_num[8:6];
						2'h2: display_d.dig = part_num[5:3];
						default: display_d.dig = part_num[2:0];
					endcase
				end else begin
					display_d.dig = bcd[blk_q*12 +: 12];
					display_d.dp  = DP_UNITS << blk_q;
				end
			end
			ST_FLASH: begin
				display_d.blank = blank_q;
			end
			default: begin
				display_d.blank = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			display_q <= '{dig: {DIG_BLANK, DIG_BLANK, DIG_BLANK},
				dp: DP_NONE, blank: 1'b0};
		end else begin
			display_q <= display_d;
		end
	end

	// ==================================================================
	// checks
	a_suction_counts: assert property (@(posedge clk) disable iff (rst)
		(!prev_q[IN_SUCT] && lvl_q[IN_SUCT] && total_cnt_q[PR_SUCT] != CNT_MAX)
		|=> total_cnt_q[PR_SUCT] == $past(total_cnt_q[PR_SUCT]) + 30'h1)
		else $error("suction pulse not counted");
	a_valve_counts: assert property (@(posedge clk) disable iff (rst)
		(valve_switch && total_cnt_q[PR_VALVE] != CNT_MAX)
		|=> total_cnt_q[PR_VALVE] == $past(total_cnt_q[PR_VALVE]) + 30'h1)
		else $error("valve switching not counted");
	a_diag_counts: assert property (@(posedge clk) disable iff (rst)
		($rose(diag_out) && total_cnt_q[PR_MON] != CNT_MAX)
		|=> total_cnt_q[PR_MON] == $past(total_cnt_q[PR_MON]) + 30'h1)
		else $error("diagnostics activation not counted");
	a_pair_together: assert property (@(posedge clk) disable iff (rst)
		(ev[PR_VALVE] && !clr_all && erase_cnt_q[PR_VALVE] != CNT_MAX)
		|=> erase_cnt_q[PR_VALVE] == $past(erase_cnt_q[PR_VALVE]) + 30'h1)
		else $error("erasable twin did not step");
	a_total_kept: assert property (@(posedge clk) disable iff (rst)
		clr_all |=> total_cnt_q[PR_SUCT] >= $past(total_cnt_q[PR_SUCT]))
		else $error("total counter was cleared");
	a_erase_zero: assert property (@(posedge clk) disable iff (rst)
		(bus_clear && !ev[PR_SUCT]) |=> erase_cnt_q[PR_SUCT] == '0)
		else $error("erasable counter not zeroed");
	a_flash_then_clear: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_FLASH && tmr_q == hold_last && !ev[PR_MON])
		|=> st_q == ST_BROWSE && erase_cnt_q[PR_MON] == '0)
		else $error("panel clear did not zero counters");
	a_counter_opens: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_BROWSE && prs.ok && !prs.menu && !pin_locked
		&& menu_item_q < IT_NCNT) |-> ##2 display_q.dp == DP_UNITS)
		else $error("counter view did not open on units");
	a_block_step: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_VIEW && menu_item_q < IT_NCNT && blk_q == BLK_UNITS
		&& prs.up && !prs.menu) |=> blk_q == 2'h1)
		else $error("up did not page to thousands");
	a_serial_opens: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_BROWSE && prs.ok && !prs.menu && !pin_locked
		&& menu_item_q == IT_SERIAL) |-> ##2 display_q.dp == DP_MILL)
		else $error("serial view did not open on millions");
	a_part_first: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_VIEW && menu_item_q == IT_PART && blk_q == BLK_UNITS)
		|=> display_q.dig[1] == $past(part_num[10])
		&& display_q.dp == PN_DP[0])
		else $error("part number does not open on first digits");
	a_pin_gate: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_PIN && !pin_ok) |=> st_q != ST_VIEW)
		else $error("view shown without PIN");

endmodule // ecc_counters_display

`default_nettype wire

// ### verification/ecc_panel_model.sv
// operator panel and fieldbus master model driving the block's inputs
`timescale 1ns/1ps
`default_nettype none

module ecc_panel_model (
	input  wire logic clk,
	output wire logic suction_pin,
	output wire logic btn_up_pin,
	output wire logic btn_down_pin,
	output wire logic btn_ok_pin,
	output wire logic btn_menu_pin,
	output logic      bus_clear
);
	import ecc_pkg::*;

	logic [4:0] pins;

	initial pins = '0;
	initial bus_clear = 1'b0;

	assign suction_pin  = pins[IN_SUCT];
	assign btn_up_pin   = pins[IN_UP];
	assign btn_down_pin = pins[IN_DOWN];
	assign btn_ok_pin   = pins[IN_OK];
	assign btn_menu_pin = pins[IN_MENU];

	// =================================================================
	// buttons
	// levels are held well past the three-stage synchroniser, and the
	// gap after release lets the readout settle before the next press
	task hold(input logic [4:0] m, input int n);
		@(negedge clk);
		pins = m;
		repeat (n) @(negedge clk);
		pins = '0;
		repeat (8) @(negedge clk);
	endtask

	task press(input int b);
		hold(5'(1 << b), 6);
	endtask

	// =================================================================
	// fieldbus
	// the caller sets it once per cycle, so a clear can share a cycle
	// with other events and two clears in a row never race each other
	task fb_clear(input logic c);
		bus_clear = c;
	endtask

endmodule // ecc_panel_model

`default_nettype wire

// ### verification/testbench.sv
// self-checking bench of the ejector counters and paged readout
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ecc_pkg::*;

	// =================================================================
	// setup
	// short hold and blink keep the run brief yet blink several times
	localparam int unsigned HOLD  = 20;
	localparam int unsigned BLINK = 3;

	typedef struct packed {
		ecc_cnt3_t tot;
		ecc_cnt3_t era;
	} ecc_note_t;

	logic       clk, rst, valve_switch, condition_monitoring, diag_out;
	logic       pin_locked, pin_ok, bus_clear, diag_prev, watch;
	logic       suction_pin, btn_up_pin, btn_down_pin, btn_ok_pin;
	logic       btn_menu_pin, blank_seen;
	logic [26:0] serial_num;
	logic [3:0] menu_item_q;
	ecc_pn_t    part_num;
	ecc_disp_t  display_q, prev_d;
	ecc_cnt3_t  total_cnt_q, erase_cnt_q;
	ecc_note_t  exp_n, last_n, prev_c;
	ecc_note_t  cq[$];
	ecc_disp_t  dq[$];
	int         err_total, n_tests, vt, ve, sn;

	ecc_counters_display #(.HOLD_CYCLES(HOLD), .BLINK_CYCLES(BLINK)) uut (
		.clk(clk), .rst(rst), .suction_pin(suction_pin),
		.btn_up_pin(btn_up_pin), .btn_down_pin(btn_down_pin),
		.btn_ok_pin(btn_ok_pin), .btn_menu_pin(btn_menu_pin),
		.valve_switch(valve_switch),
		.condition_monitoring(condition_monitoring),
		.diag_out(diag_out), .bus_clear(bus_clear),
		.pin_locked(pin_locked), .pin_ok(pin_ok),
		.serial_num(serial_num), .part_num(part_num),
		.display_q(display_q), .menu_item_q(menu_item_q),
		.total_cnt_q(total_cnt_q), .erase_cnt_q(erase_cnt_q));

	ecc_panel_model pm (
		.clk(clk), .suction_pin(suction_pin), .btn_up_pin(btn_up_pin),
		.btn_down_pin(btn_down_pin), .btn_ok_pin(btn_ok_pin),
		.btn_menu_pin(btn_menu_pin), .bus_clear(bus_clear));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// =================================================================
	// reporting and comparison
	task results;
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task fail(input string s);
		err_total++;
		$display("mismatch at %0t: %s", $time, s);
	endtask

	task chk(input logic ok, input string s);
		n_tests++;
		if (ok !== 1'b1) fail(s);
	endtask

	task cmp_cnt(input ecc_note_t e);
		n_tests++;
		if ({total_cnt_q, erase_cnt_q} !== e) fail("counter values");
	endtask

	task cmp_disp(input ecc_disp_t e);
		n_tests++;
		if (display_q !== e) fail("display readout");
	endtask

	// every count change, and every display change while watch is set, consumes the oldest note
	always @(negedge clk) begin
		if (!rst) begin
			if ({total_cnt_q, erase_cnt_q} !== prev_c) begin
				if (cq.size() == 0) fail("unexpected count change");
				else cmp_cnt(cq.pop_front());
			end
			if (watch && display_q !== prev_d) begin
				if (dq.size() == 0) fail("unexpected display change");
				else cmp_disp(dq.pop_front());
			end
			if (display_q.blank === 1'b1) blank_seen = 1'b1;
		end
		prev_c = {total_cnt_q, erase_cnt_q};
		prev_d = display_q;
	end

	initial begin
		repeat (6000) @(posedge clk);
		fail("timeout");
		results();
	end

	// =================================================================
	// expectations
	task step(input logic [2:0] ev, input logic clr);
		if (clr) exp_n.era = '0;
		for (int i = 0; i < NPAIR; i++) begin
			if (ev[i]) begin
				exp_n.tot[i]++;
				exp_n.era[i]++;
			end
		end
		if (exp_n !== last_n) cq.push_back(exp_n);
		last_n = exp_n;
	endtask

	task drive(input logic vs, cm, dg, clr);
		@(negedge clk);
		valve_switch = vs;
		condition_monitoring = cm;
		diag_out = dg;
		pm.fb_clear(clr);
		step({cm | (dg & ~diag_prev), vs, 1'b0}, clr);
		diag_prev = dg;
	endtask

	function automatic ecc_disp_t blk(input int v, input int b);
		ecc_disp_t d;
		for (int k = 0; k < 3; k++)
			d.dig[k] = 4'((v / (10 ** (3 * b + k))) % 10);
		d.dp = 3'(1 << b);
		d.blank = 1'b0;
		return d;
	endfunction

	function automatic ecc_disp_t pnb(input int b);
		ecc_disp_t d;
		for (int k = 0; k < 3; k++)
			d.dig[k] = (3 * (3 - b) + k > 10) ? DIG_BLANK
				: part_num[3 * (3 - b) + k];
		d.dp = PN_DP[b];
		d.blank = 1'b0;
		return d;
	endfunction

	task pg(input ecc_disp_t d, input int b);
		watch = 1'b1;
		dq.push_back(d);
		pm.press(b);
	endtask

	task leave;
		watch = 1'b0;
		pm.press(IN_MENU);
	endtask

	// =================================================================
	// tests
	initial begin
		void'($urandom(32'hF4A1FEFB));
		rst = 1'b1;
		{valve_switch, condition_monitoring, diag_out} = '0;
		{pin_locked, pin_ok, diag_prev, watch, blank_seen} = '0;
		err_total = 0;
		n_tests = 0;
		exp_n = '0;
		last_n = '0;
		serial_num = 27'($urandom % 100000000);
		for (int k = 0; k < 11; k++)
			part_num[k] = 4'($urandom % 10);
		// blocks 1 and 2 share their point, so their digits must differ
		if (part_num[3] == part_num[6])
			part_num[3] = 4'((part_num[6] + 4'h1) % 10);
		repeat (12) @(negedge clk);
		rst = 1'b0;
		cmp_cnt(exp_n);
		drive(1, 0, 0, 0);
		drive(0, 1, 0, 0);
		drive(0, 0, 1, 0);
		drive(0, 0, 0, 0);
		drive(0, 1, 1, 0);
		drive(1, 0, 0, 1);
		drive(0, 0, 0, 0);
		step(3'b001, 1'b0);
		pm.hold(5'h1 << IN_SUCT, 8);
		for (int i = 0; i < 300; i++)
			drive(1'($urandom), $urandom % 4 == 0, 1'($urandom),
				$urandom % 16 == 0);
		drive(1, 0, 0, 0);
		drive(0, 0, 0, 0);
		vt = int'(exp_n.tot[PR_VALVE]);
		ve = int'(exp_n.era[PR_VALVE]);
		sn = int'(serial_num);
		// a short hold must not open the menu, so ok changes nothing
		watch = 1'b1;
		pm.hold(5'h6, 10);
		pm.press(IN_OK);
		watch = 1'b0;
		pm.hold(5'h6, HOLD + 10);
		pm.press(IN_UP);
		chk(menu_item_q === 4'h1, "menu not entered");
		pg(blk(vt, 0), IN_OK);
		pg(blk(vt, 1), IN_UP);
		pg(blk(vt, 2), IN_UP);
		pm.press(IN_UP);
		pg(blk(vt, 1), IN_DOWN);
		leave();
		repeat (3) pm.press(IN_UP);
		chk(menu_item_q === 4'h4, "erasable not selected");
		pg(blk(ve, 0), IN_OK);
		leave();
		repeat (5) pm.press(IN_DOWN);
		chk(menu_item_q === IT_SERIAL, "serial not selected");
		pg(blk(sn, 2), IN_OK);
		pg(blk(sn, 1), IN_DOWN);
		pg(blk(sn, 0), IN_DOWN);
		pm.press(IN_DOWN);
		leave();
		pm.press(IN_DOWN);
		pg(pnb(0), IN_OK);
		for (int b = 1; b < 4; b++)
			pg(pnb(b), IN_DOWN);
		pg(pnb(2), IN_UP);
		leave();
		// locked menus hold the readout back until a valid pin arrives
		pin_locked = 1'b1;
		pm.press(IN_OK);
		watch = 1'b1;
		repeat (8) @(negedge clk);
		dq.push_back(pnb(0));
		pin_ok = 1'b1;
		repeat (4) @(negedge clk);
		pin_ok = 1'b0;
		repeat (8) @(negedge clk);
		leave();
		pin_locked = 1'b0;
		pm.press(IN_DOWN);
		step(3'b000, 1'b1);
		pm.hold(5'h1 << IN_OK, HOLD + 5);
		repeat (HOLD + 10) @(negedge clk);
		chk(blank_seen, "no flashing");
		chk(cq.size() == 0 && dq.size() == 0, "notes left");
		results();
	end

endmodule // testbench

`default_nettype wire
